// ### core/sla_map.svh
// constants of the signal limiter: register offsets, field positions, reset values, timing counts
// assumes values are signed hundredths of a percent and gains are thousandths
//
// Contract
// - reference absent or zero: clamp variable between low and high bias
// - dynamic bounds are reference times gain plus bias; clamp inclusively
// - inputs span -102.00..+102.00 percent; output confined to 0..100 percent
// - limit alarm goes high when variable reaches an enabled bound
// - actuation select 0/3 low, 1/4 high, 2/5 both bounds raise limit alarm
// - select 0..2: rate limit and alarm act on magnitude, both directions
// - select 3..5: positive rate limits rising, negative rate limits falling
// - limit alarm has hysteresis of 0 to 100 percent against chatter; the register accepts up to 655.35 percent unchecked
// - fast variable: ramp output at max rate; rate signed, at most 200 %/s; the slew register accepts magnitudes up to 327.68 %/s uncapped
// - rate alarm high while output ramps at the limited rate
// - panel select: limit on 1,3,4,6; rate on 2,3,5,6; 4..6 auto-ack
// - variable absent or zero: output is reference times low gain plus low bias
// - discrete alarms also given as percent: 0 is 0 %, 1 is 100 %
// - 0.01 percent is the hysteresis resolution
`ifndef SLA_MAP_SVH
`define SLA_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SLA_OFS_CTRL      6'h00
`define SLA_OFS_LOW_GAIN  6'h04
`define SLA_OFS_LOW_BIAS  6'h08
`define SLA_OFS_HIGH_GAIN 6'h0C
`define SLA_OFS_HIGH_BIAS 6'h10
`define SLA_OFS_HYST      6'h14
`define SLA_OFS_SLEW      6'h18
`define SLA_OFS_STATUS    6'h1C
`define SLA_OFS_OUTPUT    6'h20

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define SLA_CTRL_ACT_LSB   0
`define SLA_CTRL_PANEL_LSB 4
`define SLA_RST_LOW_BIAS   16'h0000
`define SLA_RST_HIGH_BIAS  16'h2710
`define SLA_RST_SLEW       16'h4E20
`define SLA_RST_GAIN       16'h0000
`define SLA_RST_HYST       16'h0000

// ----------------------------------------------------------------------------
// value ranges in hundredths of a percent
// ----------------------------------------------------------------------------
`define SLA_IN_MAX   32'sd10200
`define SLA_IN_MIN   (-32'sd10200)
`define SLA_OUT_MAX  32'sd10000
`define SLA_OUT_MIN  32'sd0
`define SLA_PCT_ONE  16'h2710
`define SLA_GAIN_DIV 32'sd1000

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SLA_CLK_MHZ        200
`define SLA_SCAN_PERIOD_MS 10
`define SLA_SCAN_CYCLES    (`SLA_SCAN_PERIOD_MS * `SLA_CLK_MHZ * 1000)
`define SLA_MS_PER_S       1000

`endif

// ### core/sla_pkg.sv
// types shared by the signal limiter files
// assumes sla_map.svh supplies the numeric constants
package sla_pkg;

  // alarm and panel flags leaving the block
  typedef struct packed {
    logic limitAlarm;
    logic rateAlarm;
    logic panelLimit;
    logic panelRate;
    logic panelAutoAck;
  } sla_alarm_t;

  // software configuration
  typedef struct packed {
    logic [2:0]  actSel;
    logic [2:0]  panelSel;
    logic [15:0] lowGain;
    logic [15:0] lowBias;
    logic [15:0] highGain;
    logic [15:0] highBias;
    logic [15:0] hyst;
    logic [15:0] slew;
  } sla_cfg_t;

  // bus answer state
  typedef enum logic {
    SLA_BUS_IDLE = 1'b0,
    SLA_BUS_ACK  = 1'b1
  } sla_bus_t;

endpackage : sla_pkg

// ### core/sla_bound_alarm.sv
// one bound comparator with hysteresis for the limit alarm
// assumes tick is a one-cycle scan pulse from the parent
`timescale 1ns/1ps
`include "sla_map.svh"
module sla_bound_alarm #(
  parameter bit IS_HIGH = 1'b0
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               tick,
  input  wire logic               enable,
  input  wire logic signed [31:0] value,
  input  wire logic signed [31:0] bound,
  input  wire logic        [15:0] hyst,
  output logic                    alarm_r
);
  import sla_pkg::*;

  logic signed [31:0] hystW;
  logic               reach;
  logic               release_;

  // ----------------------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------------------
  // hysteresis lsb is 0.01 %, so any nonzero value is a real step
  assign hystW    = $signed({16'h0000, hyst});
  assign reach    = IS_HIGH ? (value >= bound) : (value <= bound);
  assign release_ = IS_HIGH ? (value < bound - hystW) : (value > bound + hystW);

  // set on reach, clear past the band or when disabled, hold inside it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm_r <= 1'b0;
    end else if (tick) begin
      if (!enable)
        alarm_r <= 1'b0;
      else if (reach)
        alarm_r <= 1'b1;
      else if (release_)
        alarm_r <= 1'b0;
    end
  end
endmodule : sla_bound_alarm

// ### core/sla_limiter.sv
// limiter with limit alarm and rate-of-change limit, Avalon-MM register slave
// assumes inputs are synchronous to sys_clk and hold hundredths of a percent
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "sla_map.svh"
module sla_limiter #(
  parameter int unsigned SCAN_CYCLES = `SLA_SCAN_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic [5:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic signed [15:0] variableIn,
  input  wire logic               variableLinked,
  input  wire logic signed [15:0] referenceIn,
  input  wire logic               referenceLinked,
  output logic      [15:0]        limitedOut,
  output logic      [15:0]        limitAlarmPct,
  output logic      [15:0]        rateAlarmPct,
  output sla_pkg::sla_alarm_t     alarmFlags,
  output logic                    scanTick
);
  import sla_pkg::*;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic logic signed [31:0] sat(input logic signed [31:0] x,
                                             input logic signed [31:0] lo,
                                             input logic signed [31:0] hi);
    sat = (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction : sat

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic signed [31:0] sx(input logic [15:0] v);
    sx = $signed({{16{v[15]}}, v});
  endfunction : sx

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  sla_cfg_t           cfg_r;
  sla_bus_t           bus_r;
  logic [31:0]        scanCnt_r;
  logic signed [31:0] track_r;
  logic               rateAlarm_r;
  logic               ackWrite;
  logic [31:0]        rdMux;
  logic               lowAlarm;
  logic               highAlarm;
  logic [1:0]         alarmVec;
  logic [1:0]         boundEn;
  logic [2:0]         panelScan_r;

  // ----------------------------------------------------------------------------
  // scan tick
  // ----------------------------------------------------------------------------
  // free running divider; one pulse every scan period
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scanCnt_r <= 32'h0000_0000;
      scanTick  <= 1'b0;
    end else begin
      scanTick  <= (scanCnt_r == SCAN_CYCLES - 1);
      scanCnt_r <= (scanCnt_r == SCAN_CYCLES - 1) ? 32'h0000_0000 : scanCnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------------
  // inputs and bounds
  // ----------------------------------------------------------------------------
  logic signed [31:0] varV;
  logic signed [31:0] refV;
  logic signed [31:0] lowBound;
  logic signed [31:0] highBound;
  logic               varAbsent;
  logic signed [31:0] target;

  // out-of-range inputs are pinned to the accepted span
  assign varV      = variableLinked ? sat(sx(variableIn), `SLA_IN_MIN, `SLA_IN_MAX) : 32'sd0;
  assign refV      = referenceLinked ? sat(sx(referenceIn), `SLA_IN_MIN, `SLA_IN_MAX) : 32'sd0;
  // absent reference gives zero product, leaving the bare biases
  assign lowBound  = (refV * $signed({16'h0000, cfg_r.lowGain})) / `SLA_GAIN_DIV + sx(cfg_r.lowBias);
  assign highBound = (refV * $signed({16'h0000, cfg_r.highGain})) / `SLA_GAIN_DIV + sx(cfg_r.highBias);
  assign varAbsent = (varV == 32'sd0);

  // low bound checked first, so with crossed bounds a variable at or below the low bound gets the low one
  assign target = varAbsent ? lowBound :
                  (varV <= lowBound) ? lowBound :
                  (varV >= highBound) ? highBound : varV;

  // ----------------------------------------------------------------------------
  // rate limiter
  // ----------------------------------------------------------------------------
  logic signed [31:0] slewV;
  logic signed [31:0] step;
  logic signed [31:0] diff;
  logic               directional;
  logic               limRise;
  logic               limFall;
  logic               rampUp;
  logic               rampDown;
  logic signed [31:0] nextTrack;

  assign slewV = sx(cfg_r.slew);
  // per-second rate scaled to one scan; truncation keeps the ramp no faster than set
  assign step = ((slewV < 0 ? -slewV : slewV) * `SLA_SCAN_PERIOD_MS) / `SLA_MS_PER_S;
  assign diff = target - track_r;
  assign directional = (cfg_r.actSel >= 3'd3);
  // zero rate means no rate limit at all rather than a frozen output
  assign limRise = (slewV != 0) && (!directional || slewV > 0);
  assign limFall = (slewV != 0) && (!directional || slewV < 0);
  assign rampUp   = limRise && (diff > step);
  assign rampDown = limFall && (-diff > step);
  assign nextTrack = rampUp ? track_r + step : (rampDown ? track_r - step : target);

  // track holds the unconfined value so ramps continue across the 0/100 edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      track_r     <= 32'sd0;
      rateAlarm_r <= 1'b0;
      panelScan_r <= 3'd0;
    end else if (scanTick) begin
      track_r     <= nextTrack;
      rateAlarm_r <= rampUp || rampDown;
      panelScan_r <= cfg_r.panelSel;
    end
  end

  // ----------------------------------------------------------------------------
  // limit alarm comparators
  // ----------------------------------------------------------------------------
  // codes 0/3 low, 1/4 high, 2/5 both
  assign boundEn[0] = (cfg_r.actSel == 3'd0) || (cfg_r.actSel == 3'd2) ||
                      (cfg_r.actSel == 3'd3) || (cfg_r.actSel == 3'd5);
  assign boundEn[1] = (cfg_r.actSel == 3'd1) || (cfg_r.actSel == 3'd2) ||
                      (cfg_r.actSel == 3'd4) || (cfg_r.actSel == 3'd5);

  generate
    for (genvar i = 0; i < 2; i++) begin : gBound
      sla_bound_alarm #(
        .IS_HIGH (i == 1)
      ) uAlarm (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (scanTick),
        .enable  (boundEn[i]),
        .value   (varV),
        .bound   ((i == 1) ? highBound : lowBound),
        .hyst    (cfg_r.hyst),
        .alarm_r (alarmVec[i])
      );
    end
  endgenerate

  assign lowAlarm  = alarmVec[0];
  assign highAlarm = alarmVec[1];

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  logic panelLim;
  logic panelRate;
  logic signed [31:0] outConf;

  assign panelLim  = (panelScan_r == 3'd1) || (panelScan_r == 3'd3) ||
                     (panelScan_r == 3'd4) || (panelScan_r == 3'd6);
  assign panelRate = (panelScan_r == 3'd2) || (panelScan_r == 3'd3) ||
                     (panelScan_r == 3'd5) || (panelScan_r == 3'd6);
  assign outConf   = sat(track_r, `SLA_OUT_MIN, `SLA_OUT_MAX);

  // registered once more so every port leaves a flip-flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      limitedOut    <= 16'h0000;
      limitAlarmPct <= 16'h0000;
      rateAlarmPct  <= 16'h0000;
      alarmFlags    <= '0;
    end else begin
      limitedOut              <= outConf[15:0];
      limitAlarmPct           <= (lowAlarm || highAlarm) ? `SLA_PCT_ONE : 16'h0000;
      rateAlarmPct            <= rateAlarm_r ? `SLA_PCT_ONE : 16'h0000;
      alarmFlags.limitAlarm   <= lowAlarm || highAlarm;
      alarmFlags.rateAlarm    <= rateAlarm_r;
      alarmFlags.panelLimit   <= panelLim && (lowAlarm || highAlarm);
      alarmFlags.panelRate    <= panelRate && rateAlarm_r;
      alarmFlags.panelAutoAck <= (panelScan_r >= 3'd4) && (panelScan_r <= 3'd6);
    end
  end

  // ----------------------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------------------
  // two-cycle answer: waitrequest low one cycle after a request
  assign ackWrite = (bus_r == SLA_BUS_ACK) && avs_write;

  always_comb begin
    case (avs_address)
      `SLA_OFS_CTRL:      rdMux = {25'h0, cfg_r.panelSel, 1'b0, cfg_r.actSel};
      `SLA_OFS_LOW_GAIN:  rdMux = {16'h0000, cfg_r.lowGain};
      `SLA_OFS_LOW_BIAS:  rdMux = {16'h0000, cfg_r.lowBias};
      `SLA_OFS_HIGH_GAIN: rdMux = {16'h0000, cfg_r.highGain};
      `SLA_OFS_HIGH_BIAS: rdMux = {16'h0000, cfg_r.highBias};
      `SLA_OFS_HYST:      rdMux = {16'h0000, cfg_r.hyst};
      `SLA_OFS_SLEW:      rdMux = {16'h0000, cfg_r.slew};
      `SLA_OFS_STATUS:    rdMux = {28'h0, highAlarm, lowAlarm, rateAlarm_r, lowAlarm || highAlarm};
      `SLA_OFS_OUTPUT:    rdMux = {16'h0000, limitedOut};
      default:            rdMux = 32'h0000_0000;
    endcase
  end

  // request seen while idle: drop waitrequest and latch read data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_r           <= SLA_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      case (bus_r)
        SLA_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_r           <= SLA_BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rdMux : 32'h0000_0000;
          end
        end
        SLA_BUS_ACK: begin
          bus_r           <= SLA_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_r           <= SLA_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // writes land on the completing edge only; unmapped writes are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_r.actSel   <= 3'd0;
      cfg_r.panelSel <= 3'd0;
      cfg_r.lowGain  <= `SLA_RST_GAIN;
      cfg_r.lowBias  <= `SLA_RST_LOW_BIAS;
      cfg_r.highGain <= `SLA_RST_GAIN;
      cfg_r.highBias <= `SLA_RST_HIGH_BIAS;
      cfg_r.hyst     <= `SLA_RST_HYST;
      cfg_r.slew     <= `SLA_RST_SLEW;
    end else if (ackWrite) begin
      case (avs_address)
        `SLA_OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            cfg_r.actSel   <= avs_writedata[`SLA_CTRL_ACT_LSB +: 3];
            cfg_r.panelSel <= avs_writedata[`SLA_CTRL_PANEL_LSB +: 3];
          end
        end
        `SLA_OFS_LOW_GAIN:  cfg_r.lowGain  <= merge(cfg_r.lowGain, avs_writedata, avs_byteenable);
        `SLA_OFS_LOW_BIAS:  cfg_r.lowBias  <= merge(cfg_r.lowBias, avs_writedata, avs_byteenable);
        `SLA_OFS_HIGH_GAIN: cfg_r.highGain <= merge(cfg_r.highGain, avs_writedata, avs_byteenable);
        `SLA_OFS_HIGH_BIAS: cfg_r.highBias <= merge(cfg_r.highBias, avs_writedata, avs_byteenable);
        `SLA_OFS_HYST:      cfg_r.hyst     <= merge(cfg_r.hyst, avs_writedata, avs_byteenable);
        `SLA_OFS_SLEW:      cfg_r.slew     <= merge(cfg_r.slew, avs_writedata, avs_byteenable);
        default: begin
        end
      endcase
    end
  end
endmodule : sla_limiter

// ### verif/sla_limiter_sva.sv
// checker on the limiter ports: bus answer, scan timing, alarm coding
// assumes a bind onto sla_limiter, one sys_clk domain
`timescale 1ns/1ps
module sla_limiter_sva #(
  parameter int unsigned SCAN_CYCLES = 8
) (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic [5:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic signed [15:0]  variableIn,
  input wire logic                variableLinked,
  input wire logic signed [15:0]  referenceIn,
  input wire logic                referenceLinked,
  input wire logic [15:0]         limitedOut,
  input wire logic [15:0]         limitAlarmPct,
  input wire logic [15:0]         rateAlarmPct,
  input wire sla_pkg::sla_alarm_t alarmFlags,
  input wire logic                scanTick
);
  import sla_pkg::*;
  // -------------------------------------------------------------------------
  // scan gap counter; first tick after reset unchecked
  // -------------------------------------------------------------------------
  int unsigned tickGap_r;
  logic        seenTick_r;
  always_ff @(posedge sys_clk) begin
    if (rst || scanTick) begin
      tickGap_r <= 0;
    end else begin
      tickGap_r <= tickGap_r + 1;
    end
    seenTick_r <= !rst && (seenTick_r || scanTick);
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_scan_period: assert property (scanTick && seenTick_r |-> tickGap_r == SCAN_CYCLES - 1)
    else $error("scan tick period wrong");
  a_scan_bound: assert property (tickGap_r <= SCAN_CYCLES)
    else $error("scan tick missing");
  a_out_range: assert property (limitedOut <= 16'h2710)
    else $error("output above full scale");
  a_limit_pct: assert property (limitAlarmPct == (alarmFlags.limitAlarm ? 16'h2710 : 16'h0000))
    else $error("limit alarm percent mismatch");
  a_rate_pct: assert property (rateAlarmPct == (alarmFlags.rateAlarm ? 16'h2710 : 16'h0000))
    else $error("rate alarm percent mismatch");
  a_out_timing: assert property ($changed(limitedOut) |-> $past(scanTick, 2))
    else $error("output moved outside a scan");
  a_alarm_timing: assert property ($changed(alarmFlags) |-> $past(scanTick, 2))
    else $error("alarm moved outside a scan");
  a_panel_limit: assert property (alarmFlags.panelLimit |-> alarmFlags.limitAlarm)
    else $error("panel limit without alarm");
  a_panel_rate: assert property (alarmFlags.panelRate |-> alarmFlags.rateAlarm)
    else $error("panel rate without alarm");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest)
    |=> !avs_waitrequest)
    else $error("bus answer late");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
endmodule : sla_limiter_sva

// ### verif/sla_src_model.sv
// model of the upstream blocks feeding variable and reference
// assumes the bench sets requests on sys_clk edges
`timescale 1ns/1ps
module sla_src_model (
  input  wire logic signed [15:0] varReq,
  input  wire logic               varOn,
  input  wire logic signed [15:0] refReq,
  input  wire logic               refOn,
  input  wire logic               sys_clk,
  output logic signed [15:0]      variableIn,
  output logic                    variableLinked,
  output logic signed [15:0]      referenceIn,
  output logic                    referenceLinked
);
  logic [15:0] junk_r = 16'hA5A5;
  // unlinked source shows a changing pattern, never its last value
  always_ff @(posedge sys_clk) begin
    junk_r          <= junk_r + 16'h1357;
    variableLinked  <= varOn;
    referenceLinked <= refOn;
    variableIn      <= varOn ? varReq : junk_r;
    referenceIn     <= refOn ? refReq : ~junk_r;
  end
endmodule : sla_src_model

// ### verif/tb_top.sv
// bench for the limiter: Avalon register access plus scan-by-scan checks
// assumes SCAN_CYCLES cut to 8; rate step math still uses 10 ms scans
`timescale 1ns/1ps
`include "sla_map.svh"
module tb_top;
  import sla_pkg::*;
  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  logic [5:0]         avsAddr = '0;
  logic               avsRead = 1'b0;
  logic               avsWrite = 1'b0;
  logic [31:0]        avsWdata = '0;
  logic [31:0]        avsRdata;
  logic               avsWait;
  logic signed [15:0] varReq = '0;
  logic signed [15:0] refReq = '0;
  logic               varOn = 1'b0;
  logic               refOn = 1'b0;
  logic signed [15:0] variableIn, referenceIn;
  logic               variableLinked, referenceLinked, scanTick;
  logic [15:0]        limitedOut, limitAlarmPct, rateAlarmPct;
  sla_alarm_t         alarmFlags;
  int                 n_errors = 0;
  int                 checked = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  sla_src_model u_src (.varReq(varReq), .varOn(varOn), .refReq(refReq), .refOn(refOn), .sys_clk(sys_clk),
    .variableIn(variableIn), .variableLinked(variableLinked), .referenceIn(referenceIn),
    .referenceLinked(referenceLinked));
  sla_limiter #(.SCAN_CYCLES(8)) u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avsAddr),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(4'hF),
    .avs_readdata(avsRdata), .avs_waitrequest(avsWait), .variableIn(variableIn),
    .variableLinked(variableLinked), .referenceIn(referenceIn), .referenceLinked(referenceLinked),
    .limitedOut(limitedOut), .limitAlarmPct(limitAlarmPct), .rateAlarmPct(rateAlarmPct),
    .alarmFlags(alarmFlags), .scanTick(scanTick));
  // -------------------------------------------------------------------------
  // report and helpers
  // -------------------------------------------------------------------------
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge sys_clk);
    avsAddr <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWdata <= 32'(d);
    do begin
      @(posedge sys_clk);
      k++;
    end while (avsWait !== 1'b0 && k < 20);
    q = avsRdata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (k >= 20) chk("bus wait", 0, 1);
    if (k >= 20) summarize();
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(nm, e, q);
  endtask : rd
  // outputs settle one edge after the edge that samples a tick; scan waits three edges past it
  task automatic scan(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (scanTick !== 1'b1 && k < 40);
      if (k >= 40) chk("scan wait", 0, 1);
      if (k >= 40) summarize();
      repeat (3) @(posedge sys_clk);
    end
  endtask : scan
  task automatic drv(input logic [15:0] v);
    varReq <= v;
    varOn <= 1'b1;
  endtask : drv
  task automatic outc(input logic [15:0] e, input logic la);
    chk("limitedOut", 32'(e), 32'(limitedOut));
    chk("limitAlarm", 32'(la), 32'(alarmFlags.limitAlarm));
    chk("limitAlarmPct", la ? 32'h0000_2710 : 32'h0000_0000, 32'(limitAlarmPct));
  endtask : outc
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd("ctrl", `SLA_OFS_CTRL, 32'h0000_0000);
    rd("highBias", `SLA_OFS_HIGH_BIAS, 32'h0000_2710);
    rd("slew", `SLA_OFS_SLEW, 32'h0000_4E20);
    rd("unmapped", 6'h3C, 32'h0000_0000);
    wr(`SLA_OFS_SLEW, 16'h0000);
    wr(`SLA_OFS_LOW_BIAS, 16'h03E8);
    wr(`SLA_OFS_HIGH_BIAS, 16'h1F40);
    for (int a = 0; a < 6; a++) begin
      wr(`SLA_OFS_CTRL, 16'(a));
      drv(16'h0384);
      scan(2);
      outc(16'h03E8, (a % 3) != 1);
      drv(16'h2328);
      scan(2);
      outc(16'h1F40, (a % 3) != 0);
    end
    drv(16'h1388);
    scan(2);
    outc(16'h1388, 1'b0);
    wr(`SLA_OFS_CTRL, 16'h0000);
    wr(`SLA_OFS_HYST, 16'h01F4);
    drv(16'h0384);
    scan(2);
    outc(16'h03E8, 1'b1);
    drv(16'h05DC);
    scan(2);
    outc(16'h05DC, 1'b1);
    drv(16'h05DD);
    scan(2);
    outc(16'h05DD, 1'b0);
    wr(`SLA_OFS_HYST, 16'h0000);
    wr(`SLA_OFS_LOW_GAIN, 16'h01F4);
    wr(`SLA_OFS_LOW_BIAS, 16'h0000);
    wr(`SLA_OFS_HIGH_GAIN, 16'h03E8);
    wr(`SLA_OFS_HIGH_BIAS, 16'h03E8);
    refReq <= 16'h0FA0;
    refOn <= 1'b1;
    drv(16'h1770);
    scan(2);
    outc(16'h1388, 1'b0);
    drv(16'h03E8);
    scan(2);
    outc(16'h07D0, 1'b1);
    wr(`SLA_OFS_LOW_BIAS, 16'h03E8);
    drv(16'h0000);
    scan(2);
    chk("scaler", 32'h0000_0BB8, 32'(limitedOut));
    wr(`SLA_OFS_LOW_GAIN, 16'h0000);
    wr(`SLA_OFS_LOW_BIAS, 16'h0000);
    wr(`SLA_OFS_HIGH_BIAS, 16'h2EE0);
    refOn <= 1'b0;
    drv(16'h27D8);
    scan(2);
    chk("outTop", 32'h0000_2710, 32'(limitedOut));
    drv(16'hD828);
    scan(2);
    chk("outBottom", 32'h0000_0000, 32'(limitedOut));
    wr(`SLA_OFS_SLEW, 16'h4E20);
    wr(`SLA_OFS_CTRL, 16'h0030);
    drv(16'h03E8);
    scan(7);
    drv(16'h07D0);
    for (int i = 1; i <= 5; i++) begin
      scan(1);
      chk("ramp", 32'h0000_03E8 + 32'h0000_00C8 * 32'(i), 32'(limitedOut));
      if (i < 5) chk("rateAlarm", 32'h0000_0001, 32'(alarmFlags.rateAlarm));
    end
    scan(1);
    chk("rateIdle", 32'h0000_0000, 32'(alarmFlags.rateAlarm));
    drv(16'h03E8);
    scan(1);
    chk("fall", 32'h0000_0708, 32'(limitedOut));
    chk("ratePct", 32'h0000_2710, 32'(rateAlarmPct));
    chk("panelRate", 32'h0000_0001, 32'(alarmFlags.panelRate));
    scan(5);
    rd("output", `SLA_OFS_OUTPUT, 32'h0000_03E8);
    wr(`SLA_OFS_OUTPUT, 16'h1234);
    rd("outputRo", `SLA_OFS_OUTPUT, 32'h0000_03E8);
    wr(`SLA_OFS_CTRL, 16'h0033);
    scan(1);
    drv(16'h01F4);
    scan(1);
    chk("upOnlyFall", 32'h0000_01F4, 32'(limitedOut));
    drv(16'h05DC);
    scan(1);
    chk("upOnlyRise", 32'h0000_02BC, 32'(limitedOut));
    scan(5);
    wr(`SLA_OFS_SLEW, 16'hB1E0);
    scan(1);
    drv(16'h09C4);
    scan(1);
    chk("downOnlyRise", 32'h0000_09C4, 32'(limitedOut));
    drv(16'h07D0);
    scan(1);
    chk("downOnlyFall", 32'h0000_08FC, 32'(limitedOut));
    wr(`SLA_OFS_SLEW, 16'h0000);
    wr(`SLA_OFS_LOW_BIAS, 16'h03E8);
    drv(16'h0384);
    for (int p = 0; p < 7; p++) begin
      wr(`SLA_OFS_CTRL, 16'(p) << 4);
      scan(2);
      chk("panelLimit", 32'(p == 1 || p == 3 || p == 4 || p == 6), 32'(alarmFlags.panelLimit));
      chk("panelAutoAck", 32'(p >= 4), 32'(alarmFlags.panelAutoAck));
    end
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    chk("outReset", 32'h0000_0000, 32'(limitedOut));
    chk("flagsReset", 32'h0000_0000, 32'(alarmFlags));
    summarize();
  end
endmodule : tb_top
bind sla_limiter sla_limiter_sva #(.SCAN_CYCLES(SCAN_CYCLES)) u_sva (.sys_clk(sys_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .variableIn(variableIn), .variableLinked(variableLinked), .referenceIn(referenceIn),
  .referenceLinked(referenceLinked), .limitedOut(limitedOut), .limitAlarmPct(limitAlarmPct),
  .rateAlarmPct(rateAlarmPct), .alarmFlags(alarmFlags), .scanTick(scanTick));
